/* hdl/ats_pkg.sv */
// shared constants, types and helpers for the amplifier threshold/status object link
package ats_pkg;

  // amplifier model families, by display range
  typedef enum logic [2:0] {
    ATS_MODEL_FOUR      = 3'b001,
    ATS_MODEL_EIGHT     = 3'b010,
    ATS_MODEL_DUAL_DISP = 3'b100
  } ats_model_t;

  // object indices for unit 1 and the per-unit stride
  localparam logic [15:0] ATS_IDX_LEVEL    = 16'h4003;
  localparam logic [15:0] ATS_IDX_THR_ONE  = 16'h1004;
  localparam logic [15:0] ATS_IDX_THR_TWO  = 16'h4005;
  localparam logic [15:0] ATS_IDX_STATUS   = 16'h4006;
  localparam logic [15:0] ATS_UNIT_STRIDE  = 16'h0080;
  localparam logic [15:0] ATS_IDX_MEM_INIT = 16'h4042;
  localparam logic [15:0] ATS_IDX_RESET    = 16'h3010;

  // subindices and entry counts
  localparam logic [7:0] ATS_SUB_COUNT = 8'h00;
  localparam logic [7:0] ATS_SUB_CH1   = 8'h01;
  localparam logic [7:0] ATS_SUB_CH2   = 8'h02;
  localparam logic [7:0] ATS_CNT_TWO   = 8'h02;
  localparam logic [7:0] ATS_CNT_ONE   = 8'h01;

  // value ranges per model family, two's complement
  localparam logic signed [31:0] ATS_FOUR_LO  = 32'hfffff831;
  localparam logic signed [31:0] ATS_FOUR_HI  = 32'h0000270f;
  localparam logic signed [31:0] ATS_EIGHT_LO = 32'hfeced301;
  localparam logic signed [31:0] ATS_EIGHT_HI = 32'h05f5e0ff;
  localparam logic signed [31:0] ATS_DUAL_LO  = 32'hffffd8f1;
  localparam logic signed [31:0] ATS_DUAL_HI  = 32'h0000270f;
  localparam logic [31:0]        ATS_THR_RESET = 32'h00000000;

  // status word layout
  localparam int ATS_ST_NORMAL  = 0;
  localparam int ATS_ST_PWR1    = 1;
  localparam int ATS_ST_TUNE1   = 2;
  localparam int ATS_ST_PWR2    = 3;
  localparam int ATS_ST_TUNE2   = 4;
  localparam int ATS_ST_ERR_LSB = 8;
  localparam int ATS_ST_ERR_W   = 4;
  localparam int ATS_ST_MEM_ERR = 9;

  // threshold apply delay
  localparam int unsigned ATS_APPLY_MS  = 300;
  localparam int unsigned ATS_CLK_HZ    = 40_000_000;
  localparam int unsigned ATS_APPLY_CYC = ATS_APPLY_MS * (ATS_CLK_HZ / 1000);

  // host command registers
  localparam logic [4:0] ATS_REG_INDEX = 5'h00;
  localparam logic [4:0] ATS_REG_SUB   = 5'h04;
  localparam logic [4:0] ATS_REG_WDATA = 5'h08;
  localparam logic [4:0] ATS_REG_CTRL  = 5'h0c;
  localparam logic [4:0] ATS_REG_STAT  = 5'h10;
  localparam logic [4:0] ATS_REG_RDATA = 5'h14;
  localparam int ATS_CTRL_GO    = 0;
  localparam int ATS_CTRL_WRITE = 1;
  localparam int ATS_HS_BUSY    = 0;
  localparam int ATS_HS_DONE    = 1;
  localparam int ATS_HS_REFUSED = 2;
  localparam int ATS_HS_ABORT   = 3;
  localparam int ATS_HS_GUARD   = 4;
  localparam int ATS_HS_MEM_ERR = 5;
  localparam int ATS_HS_W       = 6;

  function automatic logic signed [31:0] ats_lo(ats_model_t m);
    case (m)
      ATS_MODEL_EIGHT:     ats_lo = ATS_EIGHT_LO;
      ATS_MODEL_DUAL_DISP: ats_lo = ATS_DUAL_LO;
      default:             ats_lo = ATS_FOUR_LO;
    endcase
  endfunction

  function automatic logic signed [31:0] ats_hi(ats_model_t m);
    case (m)
      ATS_MODEL_EIGHT:     ats_hi = ATS_EIGHT_HI;
      ATS_MODEL_DUAL_DISP: ats_hi = ATS_DUAL_HI;
      default:             ats_hi = ATS_FOUR_HI;
    endcase
  endfunction

  function automatic logic ats_in_range(ats_model_t m, logic signed [31:0] v);
    ats_in_range = (v >= ats_lo(m)) && (v <= ats_hi(m));
  endfunction

  // a threshold object channel entry, index already relative to unit 1
  function automatic logic ats_is_thr(logic [15:0] rel, logic [7:0] sub);
    ats_is_thr = ((rel == ATS_IDX_THR_ONE) || (rel == ATS_IDX_THR_TWO))
                 && ((sub == ATS_SUB_CH1) || (sub == ATS_SUB_CH2));
  endfunction

endpackage

/* hdl/ats_link_if.sv */
// object access link between the fieldbus master end and the amplifier unit end
`timescale 1ns/1ps
`default_nettype none
interface ats_link_if;
  logic        req;    // held until ack
  logic        wr;     // 1 = write object, 0 = read
  logic [15:0] index;
  logic [7:0]  sub;
  logic [31:0] wdata;
  logic        ack;    // one-cycle answer
  logic        abort;  // valid with ack
  logic [31:0] rdata;  // valid with ack

  modport dev (
    input  req, wr, index, sub, wdata,
    output ack, abort, rdata
  );
  modport mst (
    output req, wr, index, sub, wdata,
    input  ack, abort, rdata
  );
endinterface
`default_nettype wire

/* hdl/ats_amp_dev.sv */
// amplifier unit end: threshold, level readback and status objects
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - dark-on reads bottom level, light-on peak
// - master selects peak/bottom display before reading; the master end issues no display select, level reads follow dark_on alone
// - four-digit readback within -1999 to 9999
// - eight-digit readback within -19999999 to 99999999
// - threshold one: two signed channels, count 2
// - threshold one: normal level, area lower
// - threshold two: count 2, channel one mappable
// - threshold two is area upper limit
// - four-digit thresholds limited -1999 to 9999
// - eight-digit thresholds limited to eight digits
// - dual-display thresholds limited -9999 to 9999
// - master waits 300 ms before confirming
// - status: one read-only word, count 1
// - bit 0 normal unless any error bit
// - bits 1,2 channel one power, tuning
// - bits 3,4 channel two, two-channel only
// - bits 8-11 fixed error flags
// - memory error: master initialises then resets; the master end only raises a memory-error flag for software
module ats_amp_dev
  import ats_pkg::*;
#(
  parameter ats_model_t  AMP_MODEL   = ATS_MODEL_FOUR,
  parameter bit          TWO_CHANNEL = 1'b0,
  parameter int unsigned UNIT_NUM    = 1,
  parameter int unsigned APPLY_CYC   = ATS_APPLY_CYC
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // object link
  ats_link_if.dev                link,
  // amplifier mode and levels, same clock domain
  input  wire logic              dark_on,
  input  wire logic              area_mode,
  input  wire logic [1:0][31:0]  bottom_level,
  input  wire logic [1:0][31:0]  peak_level,
  input  wire logic [1:0][31:0]  level_now,
  // amplifier status pins, asynchronous
  input  wire logic [1:0]        dynamic_power_control_on,
  input  wire logic [1:0]        auto_tuning_on,
  input  wire logic [3:0]        amp_error,
  // comparison results and process data
  output logic      [1:0]        detect_out,
  output logic      [1:0][31:0]  thr_one_pdo,
  output logic           [31:0]  thr_two_pdo_ch1
);

  localparam int unsigned CNT_W = $clog2(APPLY_CYC + 1);
  localparam logic [15:0] UNIT_OFS = 16'((UNIT_NUM - 1) * ATS_UNIT_STRIDE);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(APPLY_CYC - 1);

  // applied thresholds: [0] one/ch1, [1] one/ch2, [2] two/ch1, [3] two/ch2
  logic [3:0][31:0] thr;
  logic [3:0][31:0] next_thr;
  logic             pend_valid;
  logic             next_pend_valid;
  logic [1:0]       pend_sel;
  logic [1:0]       next_pend_sel;
  logic [31:0]      pend_val;
  logic [31:0]      next_pend_val;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             ack_q;
  logic             next_ack;
  logic             abort_q;
  logic             next_abort;
  logic [31:0]      rdata_q;
  logic [31:0]      next_rdata;
  logic [1:0]       detect_q;
  logic [1:0]       next_detect;

  // status pin synchronisers, stage one is read only by stage two
  logic [7:0] st_meta;
  logic [7:0] st_sync;
  logic [15:0] status_word;

  // status refresh: sample the amplifier pins on every rising clock edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_meta <= 8'h00;
      st_sync <= 8'h00;
    end else begin
      st_meta <= {amp_error, auto_tuning_on, dynamic_power_control_on};
      st_sync <= st_meta;
    end
  end

  // assemble the status word from the synchronised flags
  always_comb begin
    status_word = 16'h0000;
    status_word[ATS_ST_PWR1]  = st_sync[0];
    status_word[ATS_ST_TUNE1] = st_sync[2];
    // channel two only on two-channel units
    if (TWO_CHANNEL) begin
      status_word[ATS_ST_PWR2]  = st_sync[1];
      status_word[ATS_ST_TUNE2] = st_sync[3];
    end
    // error flags, the rest stays zero
    status_word[ATS_ST_ERR_LSB +: ATS_ST_ERR_W] = st_sync[7:4];
    // normal drops on any error bit
    status_word[ATS_ST_NORMAL] = ~|status_word[15:ATS_ST_ERR_LSB];
  end

  // clamp a level into the model's display range
  function automatic logic [31:0] clamp_level(logic signed [31:0] v);
    if (v < ats_lo(AMP_MODEL)) begin
      clamp_level = ats_lo(AMP_MODEL);
    end else if (v > ats_hi(AMP_MODEL)) begin
      clamp_level = ats_hi(AMP_MODEL);
    end else begin
      clamp_level = v;
    end
  endfunction

  // object decode, pending apply and comparators
  always_comb begin
    logic [15:0] rel;
    logic        take;
    logic        ch;
    logic [1:0]  sel;
    rel  = link.index - UNIT_OFS;
    take = link.req && !ack_q;     // one answer per request
    ch   = (link.sub == ATS_SUB_CH2);
    sel  = {(rel == ATS_IDX_THR_TWO), ch};
    next_thr        = thr;
    next_pend_valid = pend_valid;
    next_pend_sel   = pend_sel;
    next_pend_val   = pend_val;
    next_cnt        = cnt;
    next_ack        = take;
    next_abort      = 1'b0;
    next_rdata      = rdata_q;
    // the new threshold lands after the apply delay, or at once when a second write arrives
    if (pend_valid) begin
      if (cnt == '0) begin
        next_thr[pend_sel] = pend_val;
        next_pend_valid    = 1'b0;
      end else begin
        next_cnt = cnt - 1'b1;
      end
    end
    if (take) begin
      next_rdata = 32'h00000000;
      if (link.wr) begin
        // range check on writes, only channel entries writable
        if (ats_is_thr(rel, link.sub) && ats_in_range(AMP_MODEL, link.wdata)) begin
          // a second write flushes the first at once so none is lost
          if (pend_valid) begin
            next_thr[pend_sel] = pend_val;
          end
          next_pend_valid = 1'b1;
          next_pend_sel   = sel;
          next_pend_val   = link.wdata;
          next_cnt        = CNT_LOAD;
        end else begin
          next_abort = 1'b1;
        end
      end else begin
        case (rel)
          ATS_IDX_LEVEL: begin
            if (link.sub == ATS_SUB_COUNT) begin
              next_rdata[7:0] = ATS_CNT_TWO;
            end else if (link.sub == ATS_SUB_CH1 || ch) begin
              next_rdata = clamp_level(dark_on ? bottom_level[ch] : peak_level[ch]);
            end else begin
              next_abort = 1'b1;
            end
          end
          ATS_IDX_THR_ONE, ATS_IDX_THR_TWO: begin
            if (link.sub == ATS_SUB_COUNT) begin
              next_rdata[7:0] = ATS_CNT_TWO;
            end else if (ats_is_thr(rel, link.sub)) begin
              next_rdata = thr[sel];
            end else begin
              next_abort = 1'b1;
            end
          end
          ATS_IDX_STATUS: begin
            if (link.sub == ATS_SUB_COUNT) begin
              next_rdata[7:0] = ATS_CNT_ONE;
            end else if (link.sub == ATS_SUB_CH1) begin
              next_rdata[15:0] = status_word;
            end else begin
              next_abort = 1'b1;
            end
          end
          default: begin
            next_abort = 1'b1;
          end
        endcase
      end
    end
    // comparators per channel
    for (int c = 0; c < 2; c++) begin
      // normal uses threshold one, area uses the window
      if (area_mode) begin
        next_detect[c] = ($signed(level_now[c]) >= $signed(thr[c]))
                         && ($signed(level_now[c]) <= $signed(thr[2 + c]));
      end else begin
        next_detect[c] = ($signed(level_now[c]) >= $signed(thr[c]));
      end
    end
  end

  // register all state except the status synchronisers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      thr        <= {4{ATS_THR_RESET}};
      pend_valid <= 1'b0;
      pend_sel   <= 2'h0;
      pend_val   <= 32'h00000000;
      cnt        <= '0;
      ack_q      <= 1'b0;
      abort_q    <= 1'b0;
      rdata_q    <= 32'h00000000;
      detect_q   <= 2'h0;
    end else begin
      thr        <= next_thr;
      pend_valid <= next_pend_valid;
      pend_sel   <= next_pend_sel;
      pend_val   <= next_pend_val;
      cnt        <= next_cnt;
      ack_q      <= next_ack;
      abort_q    <= next_abort;
      rdata_q    <= next_rdata;
      detect_q   <= next_detect;
    end
  end

  // outputs; only channel one of threshold two is mapped
  assign link.ack        = ack_q;
  assign link.abort      = abort_q;
  assign link.rdata      = rdata_q;
  assign detect_out      = detect_q;
  assign thr_one_pdo     = thr[1:0];
  assign thr_two_pdo_ch1 = thr[2];

endmodule
`default_nettype wire

/* hdl/ats_bus_mst.sv */
// fieldbus master end: command registers driving object reads and writes
`timescale 1ns/1ps
`default_nettype none
module ats_bus_mst
  import ats_pkg::*;
#(
  parameter ats_model_t  AMP_MODEL = ATS_MODEL_FOUR,
  parameter int unsigned UNIT_NUM  = 1,
  parameter int unsigned GUARD_CYC = ATS_APPLY_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // object link
  ats_link_if.mst          link,
  // software command port
  input  wire logic [4:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic      [31:0] cmd_rdata
);

  localparam int unsigned CNT_W = $clog2(GUARD_CYC + 1);
  localparam logic [15:0] UNIT_OFS = 16'((UNIT_NUM - 1) * ATS_UNIT_STRIDE);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(GUARD_CYC - 1);

  typedef enum logic [2:0] {
    ATS_H_IDLE  = 3'b001,
    ATS_H_XFER  = 3'b010,
    ATS_H_GUARD = 3'b100
  } ats_hstate_t;

  ats_hstate_t      state;
  ats_hstate_t      next_state;
  logic [15:0]      index_r;
  logic [15:0]      next_index;
  logic [7:0]       sub_r;
  logic [7:0]       next_sub;
  logic [31:0]      wdata_r;
  logic [31:0]      next_wdata;
  logic             dir_wr;
  logic             next_dir_wr;
  logic [31:0]      obj_rdata;
  logic [31:0]      next_obj_rdata;
  logic [3:0]       flags;        // done, refused, abort, mem error
  logic [3:0]       next_flags;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [31:0]      rd_q;
  logic [31:0]      next_rd;
  logic [ATS_HS_W-1:0] stat;

  // status as software sees it
  always_comb begin
    stat                 = '0;
    stat[ATS_HS_BUSY]    = (state != ATS_H_IDLE);
    stat[ATS_HS_GUARD]   = (state == ATS_H_GUARD);
    stat[ATS_HS_DONE]    = flags[0];
    stat[ATS_HS_REFUSED] = flags[1];
    stat[ATS_HS_ABORT]   = flags[2];
    stat[ATS_HS_MEM_ERR] = flags[3];
  end

  // command decode and transfer sequencing
  always_comb begin
    logic        go;
    logic        is_thr_wr;
    logic [3:0]  set;
    logic [3:0]  clr;
    next_state     = state;
    next_index     = index_r;
    next_sub       = sub_r;
    next_wdata     = wdata_r;
    next_dir_wr    = dir_wr;
    next_obj_rdata = obj_rdata;
    next_cnt       = cnt;
    next_rd        = 32'h00000000;
    set            = 4'h0;
    clr            = 4'h0;
    go        = cmd_wr && (cmd_addr == ATS_REG_CTRL) && cmd_wdata[ATS_CTRL_GO];
    is_thr_wr = ats_is_thr(index_r - UNIT_OFS, sub_r);
    // object setup registers are frozen while a transfer runs
    if (cmd_wr && state == ATS_H_IDLE) begin
      case (cmd_addr)
        ATS_REG_INDEX: next_index = cmd_wdata[15:0];
        ATS_REG_SUB:   next_sub   = cmd_wdata[7:0];
        ATS_REG_WDATA: next_wdata = cmd_wdata;
        default:       next_index = index_r;
      endcase
    end
    // write one to clear done, refused, abort, memory error
    if (cmd_wr && cmd_addr == ATS_REG_STAT) begin
      clr = {cmd_wdata[ATS_HS_MEM_ERR], cmd_wdata[ATS_HS_ABORT],
             cmd_wdata[ATS_HS_REFUSED], cmd_wdata[ATS_HS_DONE]};
    end
    case (state)
      ATS_H_IDLE: begin
        if (go) begin
          next_dir_wr = cmd_wdata[ATS_CTRL_WRITE];
          // out-of-range thresholds never reach the link
          if (cmd_wdata[ATS_CTRL_WRITE] && is_thr_wr
              && !ats_in_range(AMP_MODEL, wdata_r)) begin
            set[1] = 1'b1;
          end else begin
            next_state = ATS_H_XFER;
          end
        end
      end
      ATS_H_XFER: begin
        if (link.ack) begin
          set[0]         = 1'b1;
          set[2]         = link.abort;
          next_obj_rdata = link.rdata;
          // flag memory error so software can initialise and reset
          if (!dir_wr && !link.abort && (index_r - UNIT_OFS) == ATS_IDX_STATUS
              && sub_r == ATS_SUB_CH1) begin
            set[3] = link.rdata[ATS_ST_MEM_ERR];
          end
          // hold off 300 ms after a threshold write
          if (dir_wr && is_thr_wr && !link.abort) begin
            next_state = ATS_H_GUARD;
            next_cnt   = CNT_LOAD;
          end else begin
            next_state = ATS_H_IDLE;
          end
        end
      end
      ATS_H_GUARD: begin
        if (cnt == '0) begin
          next_state = ATS_H_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = ATS_H_IDLE;
      end
    endcase
    // a set in the same cycle as a clear wins
    next_flags = (flags & ~clr) | set;
    // read data one cycle after the strobe
    if (cmd_rd) begin
      case (cmd_addr)
        ATS_REG_INDEX: next_rd = {16'h0000, index_r};
        ATS_REG_SUB:   next_rd = {24'h000000, sub_r};
        ATS_REG_WDATA: next_rd = wdata_r;
        ATS_REG_STAT:  next_rd = {{(32 - ATS_HS_W){1'b0}}, stat};
        ATS_REG_RDATA: next_rd = obj_rdata;
        default:       next_rd = 32'h00000000;
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ATS_H_IDLE;
      index_r   <= 16'h0000;
      sub_r     <= 8'h00;
      wdata_r   <= 32'h00000000;
      dir_wr    <= 1'b0;
      obj_rdata <= 32'h00000000;
      flags     <= 4'h0;
      cnt       <= '0;
      rd_q      <= 32'h00000000;
    end else begin
      state     <= next_state;
      index_r   <= next_index;
      sub_r     <= next_sub;
      wdata_r   <= next_wdata;
      dir_wr    <= next_dir_wr;
      obj_rdata <= next_obj_rdata;
      flags     <= next_flags;
      cnt       <= next_cnt;
      rd_q      <= next_rd;
    end
  end

  // link request held for the whole transfer
  assign link.req   = (state == ATS_H_XFER);
  assign link.wr    = dir_wr;
  assign link.index = index_r;
  assign link.sub   = sub_r;
  assign link.wdata = wdata_r;
  assign cmd_rdata  = rd_q;

endmodule
`default_nettype wire

/* tb/ats_link_props.sv */
// checker for the object link: handshake timing and object answers
`timescale 1ns/1ps
`default_nettype none
module ats_link_props
  import ats_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // link signals
  input wire logic        req,
  input wire logic        wr,
  input wire logic [15:0] index,
  input wire logic [7:0]  sub,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic        abort,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // a request taken by the device at this edge
  sequence s_take;
    req && !ack;
  endsequence
  // a taken read of one subindex
  sequence s_rd(logic [7:0] s);
    s_take ##0 (!wr && sub == s);
  endsequence
  // an answer that was not refused
  sequence s_good;
    ack && !abort;
  endsequence

  // answer comes exactly one cycle after the take, request still held
  AST_ACK_NEXT: assert property (s_take |=> req && ack) else $error("link answer not next cycle");
  AST_NO_IDLE_ACK: assert property (!req |=> !ack) else $error("answer without request");
  AST_REQ_DROP: assert property (ack |=> !req && !ack) else $error("request kept after answer");
  AST_HOLD: assert property (s_take |=> $stable(index) && $stable(sub) && $stable(wr)
    && $stable(wdata)) else $error("request fields moved before answer");
  // rdata is quiet on writes and refusals so stale values never leak
  AST_QUIET_DATA: assert property (ack && (abort || wr) |-> rdata == 32'h0)
    else $error("read data on write or refusal");
  AST_COUNT_TWO: assert property (s_rd(ATS_SUB_COUNT) ##0 (index == ATS_IDX_THR_ONE ||
    index == ATS_IDX_THR_TWO) |=> s_good ##0 rdata == 32'h2) else $error("threshold count");
  AST_COUNT_ONE: assert property (s_rd(ATS_SUB_COUNT) ##0 index == ATS_IDX_STATUS
    |=> s_good ##0 rdata == 32'h1) else $error("status count");
  AST_STATUS_WORD: assert property (s_rd(ATS_SUB_CH1) ##0 index == ATS_IDX_STATUS
    |=> s_good ##0 (rdata[31:12] == 20'h0 && rdata[7:5] == 3'h0
    && rdata[0] == (rdata[11:8] == 4'h0))) else $error("status word layout");
  AST_STATUS_RO: assert property (s_take ##0 (wr && index == ATS_IDX_STATUS)
    |=> ack && abort) else $error("status write accepted");
  AST_LEVEL_RANGE: assert property (s_rd(ATS_SUB_CH1) ##0 index == ATS_IDX_LEVEL
    |=> s_good ##0 ($signed(rdata) >= ATS_FOUR_LO && $signed(rdata) <= ATS_FOUR_HI))
    else $error("level readback out of range");
  AST_THR_TAKEN: assert property (s_take ##0 (wr && (index == ATS_IDX_THR_ONE
    || index == ATS_IDX_THR_TWO) && (sub == ATS_SUB_CH1 || sub == ATS_SUB_CH2)
    && $signed(wdata) >= ATS_FOUR_LO && $signed(wdata) <= ATS_FOUR_HI) |=> s_good)
    else $error("in-range threshold refused");
endmodule
`default_nettype wire

/* tb/testbench.sv */
// testbench: master end and amplifier end joined, driven through the command port
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ats_pkg::*;
;
  localparam int APPLY = 20;
  localparam int GUARD = 24; // guard outlasts apply so readback sees the new value
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic [4:0]        cmd_addr = 5'h00;
  logic [31:0]       cmd_wdata = 32'h0;
  logic              cmd_wr = 1'b0;
  logic              cmd_rd = 1'b0;
  logic [31:0]       cmd_rdata;
  logic              dark_on = 1'b0;
  logic              area_mode = 1'b0;
  logic [1:0][31:0]  bottom_level = '0;
  logic [1:0][31:0]  peak_level = '0;
  logic [1:0][31:0]  level_now = '0;
  logic [1:0]        dynamic_power_control = 2'h0;
  logic [1:0]        tune = 2'h0;
  logic [3:0]        amp_error = 4'h0;
  logic [1:0]        detect_out;
  logic [1:0][31:0]  thr_one_pdo;
  logic [31:0]       thr_two_pdo_ch1;
  logic [31:0]       rd;
  logic [5:0]        st;
  int                failures = 0;
  int                total_checks = 0;
  logic [15:0]       wi [6] = '{16'h1004, 16'h4005, 16'h1004, 16'h4005, 16'h1004, 16'h4005};
  logic [7:0]        ws [6] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h01, 8'h02};
  logic [31:0]       wv [6] = '{32'h64, 32'hc8, 32'hfffff831, 32'h270f, 32'h2710, 32'hfffff830};
  logic [31:0]       dv [5] = '{32'h64, 32'h63, 32'hc8, 32'hc9, 32'h63};

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;

  ats_link_if lnk ();
  // master guard covers the apply delay
  ats_bus_mst #(.GUARD_CYC(GUARD)) i_ats_bus_mst (.clk_sys(clk_sys), .arst_n(arst_n),
    .link(lnk.mst), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
  ats_amp_dev #(.APPLY_CYC(APPLY)) i_ats_amp_dev (.clk_sys(clk_sys), .arst_n(arst_n),
    .link(lnk.dev), .dark_on(dark_on), .area_mode(area_mode), .bottom_level(bottom_level),
    .peak_level(peak_level), .level_now(level_now), .dynamic_power_control_on(dynamic_power_control),
    .auto_tuning_on(tune), .amp_error(amp_error), .detect_out(detect_out),
    .thr_one_pdo(thr_one_pdo), .thr_two_pdo_ch1(thr_two_pdo_ch1));
  ats_link_props i_props (.clk_sys(clk_sys), .arst_n(arst_n), .req(lnk.req), .wr(lnk.wr),
    .index(lnk.index), .sub(lnk.sub), .wdata(lnk.wdata), .ack(lnk.ack), .abort(lnk.abort),
    .rdata(lnk.rdata));

  // verdict and end of run
  task automatic report_and_stop();
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle strobes; read data is taken at the edge closing the cycle after the strobe
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cmd_wr <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    @(posedge clk_sys);
    d = cmd_rdata;
  endtask

  // one object transfer; flags cleared first so each result is fresh
  task automatic obj(input logic [15:0] i, input logic [7:0] s, input logic w,
                     input logic [31:0] d, output logic [31:0] r, output logic [5:0] f);
    logic [31:0] v;
    int n;
    wr_reg(ATS_REG_STAT, 32'h2e);
    wr_reg(ATS_REG_INDEX, {16'h0, i});
    wr_reg(ATS_REG_SUB, {24'h0, s});
    wr_reg(ATS_REG_WDATA, d);
    wr_reg(ATS_REG_CTRL, {30'h0, w, 1'b1});
    v = 32'h1;
    n = 0;
    while (v[ATS_HS_BUSY] !== 1'b0 && n < 200) begin
      rd_reg(ATS_REG_STAT, v);
      n++;
    end
    if (v[ATS_HS_BUSY] !== 1'b0) begin
      failures++;
      report_and_stop();
    end
    f = v[5:0];
    rd_reg(ATS_REG_RDATA, r);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    obj(ATS_IDX_THR_ONE, ATS_SUB_COUNT, 1'b0, 32'h0, rd, st);
    chk("thr one count", 32'h2, rd);
    obj(ATS_IDX_THR_TWO, ATS_SUB_COUNT, 1'b0, 32'h0, rd, st);
    chk("thr two count", 32'h2, rd);
    obj(ATS_IDX_STATUS, ATS_SUB_COUNT, 1'b0, 32'h0, rd, st);
    chk("status count", 32'h1, rd);
    // in-range writes incl. both range ends, read back after the guard
    for (int k = 0; k < 4; k++) begin
      obj(wi[k], ws[k], 1'b1, wv[k], rd, st);
      chk("write done", 32'h1, {31'h0, st[ATS_HS_DONE]});
      obj(wi[k], ws[k], 1'b0, 32'h0, rd, st);
      chk("threshold readback", wv[k], rd);
    end
    chk("pdo one ch1", 32'h64, thr_one_pdo[0]);
    chk("pdo one ch2", 32'hfffff831, thr_one_pdo[1]);
    chk("pdo two ch1", 32'hc8, thr_two_pdo_ch1);
    // one past each end is refused and leaves the old value
    for (int k = 4; k < 6; k++) begin
      obj(wi[k], ws[k], 1'b1, wv[k], rd, st);
      chk("range refused", 32'h1, {31'h0, st[ATS_HS_REFUSED]});
      obj(wi[k], ws[k], 1'b0, 32'h0, rd, st);
      chk("value kept", wv[k - 4 + 2 * (k - 4)], rd);
    end
    obj(ATS_IDX_STATUS, ATS_SUB_CH1, 1'b1, 32'h0, rd, st);
    chk("status write abort", 32'h1, {31'h0, st[ATS_HS_ABORT]});
    obj(ATS_IDX_THR_ONE, ATS_SUB_COUNT, 1'b1, 32'h3, rd, st);
    chk("count write abort", 32'h1, {31'h0, st[ATS_HS_ABORT]});
    // level readback follows the operating mode, clamped to four digits
    // peak reads assume the peak/bottom display mode is already selected
    @(posedge clk_sys);
    bottom_level[0] <= 32'hfffffffb;
    peak_level[0] <= 32'h00012345;
    dark_on <= 1'b1;
    obj(ATS_IDX_LEVEL, ATS_SUB_CH1, 1'b0, 32'h0, rd, st);
    chk("dark-on level", 32'hfffffffb, rd);
    dark_on <= 1'b0;
    obj(ATS_IDX_LEVEL, ATS_SUB_CH1, 1'b0, 32'h0, rd, st);
    chk("light-on level", 32'h270f, rd);
    // comparator at the edges of threshold one and the window
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      area_mode <= (k >= 2);
      level_now[0] <= dv[k];
      repeat (4) @(posedge clk_sys);
      chk("detect ch1", {31'h0, (k == 0 || k == 2)}, {31'h0, detect_out[0]});
      chk("detect ch2", 32'h1, {31'h0, detect_out[1]});
    end
    // single-channel unit: channel two bits stay clear
    @(posedge clk_sys);
    dynamic_power_control <= 2'b11;
    tune <= 2'b01;
    obj(ATS_IDX_STATUS, ATS_SUB_CH1, 1'b0, 32'h0, rd, st);
    chk("status normal", 32'h0007, rd);
    for (int k = 0; k < 4; k++) begin
      amp_error <= 4'h1 << k;
      obj(ATS_IDX_STATUS, ATS_SUB_CH1, 1'b0, 32'h0, rd, st);
      chk("status error", 32'h0006 | (32'h100 << k), rd);
      chk("memory flag", {31'h0, k == 1}, {31'h0, st[ATS_HS_MEM_ERR]});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
